// ==== core/sac_pkg.sv ====
// Package of register map, field layout and timing constants for the converter control unit.
package sac_pkg;

  // ****************************************************************
  // Register indices and byte addresses
  // ****************************************************************
  localparam logic [5:0] SAC_IDX_CTRL1   = 6'h34;
  localparam logic [5:0] SAC_IDX_CTRL2   = 6'h35;
  localparam logic [5:0] SAC_IDX_RES_LO  = 6'h36;
  localparam logic [5:0] SAC_IDX_RES_HI  = 6'h37;
  localparam int         SAC_ADDR_W      = 8;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int         SAC_C1_GO       = 7;
  localparam int         SAC_C1_MODE_HI  = 6;
  localparam int         SAC_C1_MODE_LO  = 5;
  localparam int         SAC_C1_GATE     = 4;
  localparam int         SAC_C2_DONE     = 7;
  localparam int         SAC_C2_BUSY     = 6;
  localparam logic [7:0] SAC_RESET_BYTE  = 8'h00;

  // Operating mode codes; the code 2'b10 is reserved and never starts a conversion.
  localparam logic [1:0] SAC_MODE_STOP   = 2'h0;
  localparam logic [1:0] SAC_MODE_SINGLE = 2'h1;
  localparam logic [1:0] SAC_MODE_REPEAT = 2'h3;

  // ****************************************************************
  // Conversion timing in core-clock cycles
  // ****************************************************************
  localparam int         SAC_CYC_T0      = 39;
  localparam int         SAC_CYC_T1      = 78;
  localparam int         SAC_CYC_T2      = 156;
  localparam int         SAC_CYC_T3      = 312;
  localparam int         SAC_CYC_T4      = 624;
  localparam int         SAC_CYC_T5      = 1248;
  // A conversion is split into 3 sample slots and 10 bit trials of equal length.
  localparam int         SAC_SLOTS       = 13;
  localparam int         SAC_SAMPLE_SLOTS = 3;
  localparam int         SAC_BITS        = 10;

  // Returns the bit-trial slot length for a conversion time code.
  function automatic logic [6:0] sac_slot_len(input logic [2:0] ack);
    logic [6:0] len;
    len = 7'(SAC_CYC_T0 / SAC_SLOTS);
    case (ack)
      3'h1:    len = 7'(SAC_CYC_T1 / SAC_SLOTS);
      3'h2:    len = 7'(SAC_CYC_T2 / SAC_SLOTS);
      3'h3:    len = 7'(SAC_CYC_T3 / SAC_SLOTS);
      3'h4:    len = 7'(SAC_CYC_T4 / SAC_SLOTS);
      3'h5:    len = 7'(SAC_CYC_T5 / SAC_SLOTS);
      default: len = 7'(SAC_CYC_T0 / SAC_SLOTS);
    endcase
    return len;
  endfunction

  // True when a byte address selects the register with the given index.
  function automatic logic sac_addr_is(input logic [7:0] addr, input logic [5:0] idx);
    return addr == {idx, 2'b00};
  endfunction

endpackage

// ==== core/sac_seq_if.sv ====
// Interface between the register front end and the successive-approximation sequencer.
`timescale 1ns/1ps
interface sac_seq_if;
  logic       start;
  logic       abort;
  logic [2:0] ack;
  logic       comp;
  logic       busy;
  logic       done;
  logic       sampling;
  logic [9:0] code;

  modport ctl (output start, output abort, output ack, output comp,
               input busy, input done, input sampling, input code);
  modport seq (input start, input abort, input ack, input comp,
               output busy, output done, output sampling, output code);
endinterface

// ==== core/sac_seq.sv ====
// Successive-approximation sequencer: sampling phase, ten bit trials and result strobe.
`timescale 1ns/1ps
module sac_seq
  import sac_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  sac_seq_if.seq    sq
);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_TRIAL, SEQ_STORE} sac_seq_state_type;

  sac_seq_state_type st_q, st_d;
  logic [8:0]        ph_q, ph_d;
  logic [6:0]        per_q, per_d;
  logic [3:0]        bit_q, bit_d;
  logic [9:0]        code_q, code_d;
  logic              busy_q, busy_d;
  logic              samp_q, samp_d;
  logic              done_q, done_d;
  logic [10:0]       len_q;

  assign sq.busy     = busy_q;
  assign sq.done     = done_q;
  assign sq.sampling = samp_q;
  assign sq.code     = code_q;

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  // Timing comes from the slot length latched at start, so a late change of the time code cannot stretch a run.
  always_comb
  begin
    st_d   = st_q;
    ph_d   = ph_q;
    per_d  = per_q;
    bit_d  = bit_q;
    code_d = code_q;
    busy_d = busy_q;
    samp_d = samp_q;
    done_d = 1'b0;
    case (st_q)
      SEQ_IDLE:
      begin
        if (sq.start)
        begin
          per_d  = sac_slot_len(sq.ack);
          ph_d   = 9'h000;
          code_d = 10'h000;
          busy_d = 1'b1;
          samp_d = 1'b1;
          st_d   = SEQ_SAMPLE;
        end
      end
      SEQ_SAMPLE:
      begin
        if (ph_q == 9'(SAC_SAMPLE_SLOTS * per_q) - 9'h001)
        begin
          ph_d   = 9'h000;
          samp_d = 1'b0;
          bit_d  = 4'(SAC_BITS - 1);
          code_d = 10'h200;
          st_d   = SEQ_TRIAL;
        end
        else
          ph_d = ph_q + 9'h001;
      end
      SEQ_TRIAL:
      begin
        if (ph_q == {2'b00, per_q} - 9'h001)
        begin
          ph_d           = 9'h000;
          code_d[bit_q]  = sq.comp;
          if (bit_q == 4'h0)
            st_d = SEQ_STORE;
          else
          begin
            bit_d                = bit_q - 4'h1;
            code_d[bit_q - 4'h1] = 1'b1;
          end
        end
        else
          ph_d = ph_q + 9'h001;
      end
      SEQ_STORE:
      begin
        done_d = 1'b1;
        busy_d = 1'b0;
        st_d   = SEQ_IDLE;
      end
      default: st_d = SEQ_IDLE;
    endcase
    // A forced stop ends the run at once and never strobes a result.
    if (sq.abort)
    begin
      st_d   = SEQ_IDLE;
      busy_d = 1'b0;
      samp_d = 1'b0;
      done_d = 1'b0;
    end
  end

  // Sequencer registers.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_q   <= SEQ_IDLE;
      ph_q   <= 9'h000;
      per_q  <= 7'h00;
      bit_q  <= 4'h0;
      code_q <= 10'h000;
      busy_q <= 1'b0;
      samp_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      ph_q   <= ph_d;
      per_q  <= per_d;
      bit_q  <= bit_d;
      code_q <= code_d;
      busy_q <= busy_d;
      samp_q <= samp_d;
      done_q <= done_d;
    end
  end

  // Cycle count of the current run, read only by the checks below.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      len_q <= 11'h000;
    else if (st_q == SEQ_IDLE)
      len_q <= 11'h000;
    else
      len_q <= len_q + 11'h001;
  end

  property p_conv_len;
    @(posedge sys_clk) disable iff (srst)
    done_q |-> len_q == 11'(SAC_SLOTS * per_q) + 11'h001;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length does not match time code");

  property p_busy_span;
    @(posedge sys_clk) disable iff (srst)
    (st_q == SEQ_IDLE && sq.start && !sq.abort) |=> busy_q && samp_q && ph_q == 9'h000;
  endproperty
  a_busy_span: assert property (p_busy_span) else $error("start did not raise busy");

endmodule

// ==== core/sac_top.sv ====
// Register front end and control of the ten-bit successive-approximation converter.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps

// Contract
// - A written start bit self-clears once conversion begins; it then reads zero.
// - Mode 00 disables and stops, 01 single, 11 repeat, 10 reserved.
// - Input enable zero disconnects every channel; one connects the selected channel.
// - Channel codes 0 to 7 pick inputs; 8 and above are reserved.
// - Low-power entry clears start bit, mode field and input enable.
// - Low-power entry clears done flag and busy flag.
// - Done flag in control two bit 7 reads one after a completed conversion.
// - Busy flag in bit 6 reads one while a conversion runs.
// - Reading the high result clears done; a new single start clears it too.
// - Time code picks 39, 78, 156, 312, 624 or 1248 core cycles.
// - Control two bits 3 to 5 always read zero.
// - Start plus store latency stays within 10, 32 or 128 cycles.
// - The converter reference current is off whenever no conversion runs.
// - Low result register is read-only, resets to zero, holds bits 7 to 0.
// - Completion stores the result, sets done and pulses the completion request.
// - Repeat mode starts the next conversion right after each completion.
// - Writing stop halts at once, stores nothing, clears done, busy and results.
// - Completion between low and high result reads is dropped, without a request.
module sac_top
  import sac_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        light_sleep_entry,
  input  wire logic        comp_in,
  output logic      [2:0]  ana_channel,
  output logic             ana_input_gate,
  output logic             ana_sample,
  output logic             dac_reference_current,
  output logic      [9:0]  dac_code,
  output logic             conv_complete_irq
);

  sac_seq_if sq ();

  sac_seq u_seq (
    .sys_clk (sys_clk),
    .srst    (srst),
    .sq      (sq.seq)
  );

  // ****************************************************************
  // Comparator synchroniser
  // ****************************************************************
  logic cmp1_q, cmp2_q;
  logic cmp1_d, cmp2_d;

  // Two stages only: a longer chain would deliver the trial result after a three-cycle slot has ended.
  always_comb
  begin
    cmp1_d = comp_in;
    cmp2_d = cmp1_q;
  end

  // Synchroniser stages for the analog comparator output.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cmp1_q <= 1'b0;
      cmp2_q <= 1'b0;
    end
    else
    begin
      cmp1_q <= cmp1_d;
      cmp2_q <= cmp2_d;
    end
  end

  // ****************************************************************
  // Registers and control state
  // ****************************************************************
  logic        go_q, go_d;
  logic [1:0]  mode_q, mode_d;
  logic        gate_q, gate_d;
  logic [3:0]  chan_q, chan_d;
  logic [2:0]  ack_q, ack_d;
  logic        done_q, done_d;
  logic [9:0]  res_q, res_d;
  logic        lo_rd_q, lo_rd_d;
  logic        wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic        start_q, start_d;
  logic        abort_q, abort_d;
  logic        irq_q, irq_d;
  logic        agate_q, agate_d;
  logic        take;
  logic        wr0;
  logic        stop_wr;

  assign take    = (avs_read || avs_write) && !wait_q;
  assign wr0     = take && avs_write && avs_byteenable[0];
  assign stop_wr = wr0 && sac_addr_is(avs_address, SAC_IDX_CTRL1)
                   && avs_writedata[SAC_C1_MODE_HI:SAC_C1_MODE_LO] == SAC_MODE_STOP;

  assign sq.start = start_q;
  assign sq.abort = abort_q;
  assign sq.ack   = ack_q;
  assign sq.comp  = cmp2_q;

  // Next values of all software-visible and control state; later statements take priority.
  always_comb
  begin
    go_d    = go_q;
    mode_d  = mode_q;
    gate_d  = gate_q;
    chan_d  = chan_q;
    ack_d   = ack_q;
    done_d  = done_q;
    res_d   = res_q;
    lo_rd_d = lo_rd_q;
    rdata_d = rdata_q;
    start_d = 1'b0;
    abort_d = 1'b0;
    irq_d   = 1'b0;
    // Each request gets exactly one wait cycle, then waitrequest drops for one cycle.
    wait_d  = !((avs_read || avs_write) && wait_q);
    if ((avs_read || avs_write) && wait_q)
    begin
      rdata_d = 32'h0000_0000;
      if (avs_read)
      begin
        if (sac_addr_is(avs_address, SAC_IDX_CTRL1))
          rdata_d[7:0] = {go_q, mode_q, gate_q, chan_q};
        else if (sac_addr_is(avs_address, SAC_IDX_CTRL2))
          rdata_d[7:0] = {done_q, sq.busy, 3'b000, ack_q};
        else if (sac_addr_is(avs_address, SAC_IDX_RES_LO))
          rdata_d[7:0] = res_q[7:0];
        else if (sac_addr_is(avs_address, SAC_IDX_RES_HI))
          rdata_d[7:0] = {6'b000000, res_q[9:8]};
      end
    end
    // Side effects of result reads take place at the accepting edge.
    if (take && avs_read)
    begin
      if (sac_addr_is(avs_address, SAC_IDX_RES_LO))
        lo_rd_d = 1'b1;
      else if (sac_addr_is(avs_address, SAC_IDX_RES_HI))
      begin
        done_d  = 1'b0;
        lo_rd_d = 1'b0;
      end
    end
    // Register writes; bit 3 of control two is not stored.
    if (wr0)
    begin
      if (sac_addr_is(avs_address, SAC_IDX_CTRL1))
      begin
        mode_d = avs_writedata[SAC_C1_MODE_HI:SAC_C1_MODE_LO];
        gate_d = avs_writedata[SAC_C1_GATE];
        chan_d = avs_writedata[3:0];
        go_d   = avs_writedata[SAC_C1_GO];
      end
      else if (sac_addr_is(avs_address, SAC_IDX_CTRL2))
        ack_d = avs_writedata[2:0];
    end
    // Start: the request bit is taken by the sequencer and clears itself.
    if (go_q && !sq.busy)
    begin
      go_d = 1'b0;
      if (mode_q == SAC_MODE_SINGLE || mode_q == SAC_MODE_REPEAT)
      begin
        start_d = 1'b1;
        done_d  = 1'b0;
      end
    end
    // Completion stores and flags, unless a low-half read is still waiting for its high half.
    if (sq.done)
    begin
      if (!lo_rd_q)
      begin
        res_d  = sq.code;
        done_d = 1'b1;
        irq_d  = 1'b1;
      end
      if (mode_q == SAC_MODE_REPEAT)
        start_d = 1'b1;
    end
    // A stop write halts the sequencer and wipes flags and results.
    if (stop_wr)
    begin
      abort_d = 1'b1;
      start_d = 1'b0;
      go_d    = 1'b0;
      done_d  = 1'b0;
      res_d   = 10'h000;
      lo_rd_d = 1'b0;
      irq_d   = 1'b0;
    end
    // Low-power entry returns control to the disabled state.
    if (light_sleep_entry)
    begin
      abort_d = 1'b1;
      start_d = 1'b0;
      go_d    = 1'b0;
      mode_d  = SAC_MODE_STOP;
      gate_d  = 1'b0;
      done_d  = 1'b0;
      res_d   = 10'h000;
      lo_rd_d = 1'b0;
      irq_d   = 1'b0;
    end
    // Reserved channel codes keep every input disconnected.
    agate_d = gate_d && !chan_d[3];
  end

  // Control and register flip-flops.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      go_q    <= 1'b0;
      mode_q  <= SAC_MODE_STOP;
      gate_q  <= 1'b0;
      chan_q  <= 4'h0;
      ack_q   <= 3'h0;
      done_q  <= 1'b0;
      res_q   <= 10'h000;
      lo_rd_q <= 1'b0;
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
      start_q <= 1'b0;
      abort_q <= 1'b0;
      irq_q   <= 1'b0;
      agate_q <= 1'b0;
    end
    else
    begin
      go_q    <= go_d;
      mode_q  <= mode_d;
      gate_q  <= gate_d;
      chan_q  <= chan_d;
      ack_q   <= ack_d;
      done_q  <= done_d;
      res_q   <= res_d;
      lo_rd_q <= lo_rd_d;
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      start_q <= start_d;
      abort_q <= abort_d;
      irq_q   <= irq_d;
      agate_q <= agate_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The reference current follows the registered busy flag of the sequencer.
  assign avs_readdata          = rdata_q;
  assign avs_waitrequest       = wait_q;
  assign ana_channel           = chan_q[2:0];
  assign ana_input_gate        = agate_q;
  assign ana_sample            = sq.sampling;
  assign dac_reference_current = sq.busy;
  assign dac_code              = sq.code;
  assign conv_complete_irq     = irq_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_go_clear;
    @(posedge sys_clk) disable iff (srst)
    (go_q && !sq.busy) |=> !go_q;
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("start bit did not self-clear");

  property p_start_latency;
    @(posedge sys_clk) disable iff (srst)
    (go_q && !sq.busy && mode_q == SAC_MODE_SINGLE && !stop_wr && !light_sleep_entry) |-> ##2 sq.busy;
  endproperty
  a_start_latency: assert property (p_start_latency) else $error("busy not raised two cycles after start");

  property p_stop;
    @(posedge sys_clk) disable iff (srst)
    stop_wr |=> !done_q && res_q == 10'h000 ##1 !sq.busy;
  endproperty
  a_stop: assert property (p_stop) else $error("stop write did not clear state");

  property p_sleep;
    @(posedge sys_clk) disable iff (srst)
    light_sleep_entry |=> mode_q == SAC_MODE_STOP && !gate_q && !go_q && !done_q ##1 !sq.busy;
  endproperty
  a_sleep: assert property (p_sleep) else $error("low-power entry did not clear control");

  property p_hi_read;
    @(posedge sys_clk) disable iff (srst)
    (take && avs_read && sac_addr_is(avs_address, SAC_IDX_RES_HI) && !sq.done) |=> !done_q;
  endproperty
  a_hi_read: assert property (p_hi_read) else $error("high result read left done set");

  property p_complete;
    @(posedge sys_clk) disable iff (srst)
    (sq.done && !lo_rd_q && !stop_wr && !light_sleep_entry) |=> irq_q && done_q && res_q == $past(sq.code);
  endproperty
  a_complete: assert property (p_complete) else $error("completion not stored and flagged");

  property p_drop;
    @(posedge sys_clk) disable iff (srst)
    (sq.done && lo_rd_q && !stop_wr && !light_sleep_entry) |=> !irq_q && res_q == $past(res_q);
  endproperty
  a_drop: assert property (p_drop) else $error("torn-read completion was not dropped");

  property p_repeat;
    @(posedge sys_clk) disable iff (srst)
    (sq.done && mode_q == SAC_MODE_REPEAT && !stop_wr && !light_sleep_entry) |=> start_q ##1 sq.busy;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat mode did not restart");

  property p_ctrl2_zero;
    @(posedge sys_clk) disable iff (srst)
    (wait_q && avs_read && sac_addr_is(avs_address, SAC_IDX_CTRL2)) |=> !avs_waitrequest && avs_readdata[5:3] == 3'b000;
  endproperty
  a_ctrl2_zero: assert property (p_ctrl2_zero) else $error("control two reserved bits read nonzero");

  property p_gate;
    @(posedge sys_clk) disable iff (srst)
    (!gate_d || chan_d[3]) |=> !ana_input_gate;
  endproperty
  a_gate: assert property (p_gate) else $error("input gate open while disabled or reserved");

endmodule

// ==== tb/sac_front_model.sv ====
// Behavioural analog front end: channel levels, sample-hold and comparator.
`timescale 1ns/1ps
module sac_front_model
(
  input  wire logic       sys_clk,
  input  wire logic [2:0] ana_channel,
  input  wire logic       ana_input_gate,
  input  wire logic       ana_sample,
  input  wire logic [9:0] dac_code,
  output logic            comp_in
);
  // ****************************************************************
  // Sample-hold and comparator
  // ****************************************************************
  logic [9:0] held_q = 10'h000;

  // The hold follows the gated channel level while sampling; a closed gate reads ground.
  always @(posedge sys_clk)
  begin
    if (ana_sample)
    begin
      held_q <= ana_input_gate ? {ana_channel, 7'h35} : 10'h000;
    end
  end

  // The held level sits half a step above its code, so the trial result is exact.
  assign comp_in = ({held_q, 1'b1} > {dac_code, 1'b0});
endmodule

// ==== tb/test_sac_top.sv ====
// Self-checking testbench of the converter control unit.
`timescale 1ns/1ps
module test_sac_top;
  import sac_pkg::*;
  // ****************************************************************
  // Signals, clock and design
  // ****************************************************************
  localparam logic [7:0] A_C1 = {SAC_IDX_CTRL1, 2'b00};
  localparam logic [7:0] A_C2 = {SAC_IDX_CTRL2, 2'b00};
  localparam logic [7:0] A_LO = {SAC_IDX_RES_LO, 2'b00};
  localparam logic [7:0] A_HI = {SAC_IDX_RES_HI, 2'b00};
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        light_sleep_entry = 1'b0;
  logic        comp_in;
  logic [2:0]  ana_channel;
  logic        ana_input_gate;
  logic        ana_sample;
  logic        dac_reference_current;
  logic [9:0]  dac_code;
  logic        conv_complete_irq;
  logic [7:0]  q;
  int          err_count = 0;
  int          num_checks = 0;
  int          irq_n = 0;
  int          run_len = 0;
  int          last_len = 0;

  // The clock toggles every half period of 10 ns.
  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end

  sac_top dut (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .light_sleep_entry(light_sleep_entry),
    .comp_in(comp_in), .ana_channel(ana_channel), .ana_input_gate(ana_input_gate), .ana_sample(ana_sample),
    .dac_reference_current(dac_reference_current), .dac_code(dac_code), .conv_complete_irq(conv_complete_irq));

  sac_front_model front (.sys_clk(sys_clk), .ana_channel(ana_channel), .ana_input_gate(ana_input_gate),
    .ana_sample(ana_sample), .dac_code(dac_code), .comp_in(comp_in));

  // Counts completion requests and measures how long the reference current stays on.
  always @(posedge sys_clk)
  begin
    if (conv_complete_irq === 1'b1) irq_n++;
    if (dac_reference_current === 1'b1) run_len++;
    else if (run_len != 0)
    begin
      last_len = run_len;
      run_len = 0;
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Compares one value and counts the result.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds one request until waitrequest is sampled low, then takes the read data.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  // Reads a register and compares it with the expected byte.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk({24'h0, q}, {24'h0, exp});
  endtask

  // Polls the done flag until it is set.
  task automatic wait_done();
    do bus(1'b0, A_C2, 8'h00); while (q[SAC_C2_DONE] !== 1'b1);
  endtask

  // Returns the conversion length for a time code; reserved codes act as the shortest.
  function automatic int cyc(input int c);
    case (c)
      1: return SAC_CYC_T1;
      2: return SAC_CYC_T2;
      3: return SAC_CYC_T3;
      4: return SAC_CYC_T4;
      5: return SAC_CYC_T5;
      default: return SAC_CYC_T0;
    endcase
  endfunction

  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values, including an unmapped address.
  task automatic t_reset();
    rd(A_C1, 8'h00);
    rd(A_C2, 8'h00);
    rd(A_LO, 8'h00);
    rd(A_HI, 8'h00);
    rd(8'hE0, 8'h00);
  endtask

  // Single conversions at every time code, reserved codes included.
  task automatic t_times();
    int n;
    for (int c = 0; c < 8; c++)
    begin
      wr(A_C2, 8'(c));
      wr(A_C1, 8'h33);
      n = irq_n;
      wr(A_C1, 8'hB3);
      rd(A_C1, 8'h33);
      rd(A_C2, 8'h40 | 8'(c));
      wait_done();
      chk(last_len, cyc(c) + 1);
      chk(irq_n, n + 1);
      rd(A_C2, 8'h80 | 8'(c));
      rd(A_LO, 8'hB5);
      rd(A_HI, 8'h01);
      rd(A_C2, 8'(c));
    end
  endtask

  // Reserved mode, input gate, channel codes and a restart without reading the high result.
  task automatic t_gate();
    wr(A_C2, 8'h00);
    wr(A_C1, 8'h45);
    repeat (2) @(posedge sys_clk);
    chk(ana_input_gate, 1'b0);
    wr(A_C1, 8'hC5);
    rd(A_C2, 8'h00);
    wr(A_C1, 8'h25);
    wr(A_C1, 8'hA5);
    wait_done();
    rd(A_LO, 8'h00);
    rd(A_HI, 8'h00);
    wr(A_C1, 8'h35);
    repeat (2) @(posedge sys_clk);
    chk({ana_input_gate, ana_channel}, 4'hD);
    wr(A_C1, 8'hB5);
    wait_done();
    wr(A_C1, 8'hB5);
    rd(A_C1, 8'h35);
    rd(A_C2, 8'h40);
    wait_done();
    rd(A_LO, 8'hB5);
    rd(A_HI, 8'h02);
    wr(A_C1, 8'h19);
    repeat (2) @(posedge sys_clk);
    chk(ana_input_gate, 1'b0);
  endtask

  // Repeat mode, a completion dropped between the result reads, then a forced stop.
  task automatic t_repeat();
    int n;
    wr(A_C1, 8'h75);
    wr(A_C1, 8'hF5);
    wait_done();
    n = irq_n;
    rd(A_LO, 8'hB5);
    repeat (50) @(posedge sys_clk);
    chk(irq_n, n);
    rd(A_HI, 8'h02);
    n = irq_n;
    wait_done();
    chk(irq_n, n + 1);
    wr(A_C1, 8'h15);
    repeat (3) @(posedge sys_clk);
    chk(dac_reference_current, 1'b0);
    rd(A_C2, 8'h00);
    rd(A_LO, 8'h00);
    rd(A_HI, 8'h00);
  endtask

  // Low-power entry in the middle of a long conversion.
  task automatic t_sleep();
    wr(A_C2, 8'h05);
    wr(A_C1, 8'h75);
    wr(A_C1, 8'hF5);
    repeat (20) @(posedge sys_clk);
    light_sleep_entry <= 1'b1;
    @(posedge sys_clk);
    light_sleep_entry <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(dac_reference_current, 1'b0);
    rd(A_C1, 8'h05);
    rd(A_C2, 8'h05);
  endtask

  // Main sequence after a reset of three cycles.
  initial
  begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_times();
    t_gate();
    t_repeat();
    t_sleep();
    end_of_test();
  end

  // Cuts a hang short well after the expected run length.
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    end_of_test();
  end
endmodule
